// >>> rtl/psc_loader.sv
// Strap sampling loader with APB access to the strapped management registers.

// Behaviour
// (RL1) Load autoneg and scrambler straps at reset.
// (RL2) Load NRZI and block-code straps at reset.
// (RL3) Load speed strap into speed select.
// (RL4) After loading, only management writes change registers.
// (RL5) Patterns 111 and 110 set advertisement bits.
// (RL6) Select 10: 100 half, full if duplex.
// (RL7) Select 01: 10 half, full if duplex.
// (RL8) Autoneg off keeps advertisement defaults.
// (RL9) Low pad means active-high LED, else low.
// (RL10) Five pad levels form the PHY address.
// (RL11) Address zero sets the isolate bit.
// (RL12) Answer only at own PHY address.
// (RL13) Autoneg off: select A sets MLT-3 bypass.
// (RL14) Autoneg off: select B sets loopback.
// (RL15) Pad levels stored in mode bits 7..3.
// (RL16) Reset done rises once loading finished.
// (RL17) Straps captured once, when the reset wait count ends.
// (RL18) Unlisted patterns keep advertisement defaults.
module psc_loader #(
  parameter int unsigned RST_CYCLES = psc_pkg::RST_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [psc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire psc_pkg::psc_strap_t strap_in,
  input wire logic [psc_pkg::PAD_W-1:0] pad_in,
  input wire logic [psc_pkg::PAD_W-1:0] led_state,
  output logic [psc_pkg::PAD_W-1:0] led_o,
  output logic [psc_pkg::PAD_W-1:0] led_oe,
  output logic reset_done,
  output psc_pkg::psc_cfg_t cfg_o
);

  psc_pkg::psc_state_t st_r;
  psc_pkg::psc_strap_t strap_s;
  logic [psc_pkg::PAD_W-1:0] pad_s;
  logic [17:0] cnt_r;
  logic [15:0] ctl_r;
  logic [15:0] adv_r;
  logic [15:0] tx_r;
  logic [15:0] mode_r;
  logic [15:0] ctl_load;
  logic [15:0] adv_load;
  logic [15:0] tx_load;
  logic [psc_pkg::PAD_W-1:0] led_pol_r;
  logic reset_done_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [4:0] acc_idx;
  logic acc_hit;
  logic acc_known;
  logic commit;
  logic [15:0] rd_word;

  psc_sync #(
    .W(psc_pkg::STRAP_W + psc_pkg::PAD_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({strap_in, pad_in}),
    .q({strap_s, pad_s})
  );

  // The counter also covers the synchroniser delay, so straps are settled
  // long before the single load cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= psc_pkg::ST_WAIT;
      cnt_r <= 18'h00000;
    end else begin
      unique case (st_r)
        psc_pkg::ST_WAIT: begin
          if (cnt_r >= 18'(RST_CYCLES - 1)) begin
            st_r <= psc_pkg::ST_LOAD;
          end else begin
            cnt_r <= cnt_r + 18'h00001;
          end
        end
        psc_pkg::ST_LOAD: begin
          st_r <= psc_pkg::ST_RUN; // RL17
        end
        psc_pkg::ST_RUN: begin
          st_r <= psc_pkg::ST_RUN;
        end
        default: begin
          st_r <= psc_pkg::ST_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_done_r <= 1'b0;
    end else if (st_r == psc_pkg::ST_LOAD) begin
      reset_done_r <= 1'b1; // RL16
    end
  end

  always_comb begin
    ctl_load = psc_pkg::CTL_RST;
    ctl_load[psc_pkg::CTL_AUTONEG] = strap_s.autoneg; // RL1
    ctl_load[psc_pkg::CTL_SPEED] = strap_s.speed; // RL3
    ctl_load[psc_pkg::CTL_ISOLATE] = (pad_s == psc_pkg::PAD_ISOLATE); // RL11
    if (!strap_s.autoneg) begin
      ctl_load[psc_pkg::CTL_LOOPBACK] = strap_s.adv_select_b; // RL14
      ctl_load[psc_pkg::CTL_DUPLEX] = strap_s.duplex;
    end
  end

  always_comb begin
    tx_load = psc_pkg::TX_RST;
    tx_load[psc_pkg::TX_NRZI] = strap_s.nrzi; // RL2
    tx_load[psc_pkg::TX_BLOCK_CODE] = strap_s.block_code; // RL2
    tx_load[psc_pkg::TX_SCRAMBLE_OFF] = strap_s.scramble_off; // RL1
    if (!strap_s.autoneg) begin
      tx_load[psc_pkg::TX_MLT3_BYPASS] = strap_s.adv_select_a; // RL13
    end
  end

  always_comb begin
    adv_load = psc_pkg::ADV_RST; // RL8 RL18
    if (strap_s.autoneg) begin
      unique case ({strap_s.adv_select_a, strap_s.adv_select_b})
        2'b11: begin
          adv_load[psc_pkg::ADV_100_FULL] = strap_s.duplex; // RL5
          adv_load[psc_pkg::ADV_100_HALF] = 1'b1;
          adv_load[psc_pkg::ADV_10_FULL] = strap_s.duplex;
          adv_load[psc_pkg::ADV_10_HALF] = 1'b1;
        end
        2'b10: begin
          adv_load[psc_pkg::ADV_100_FULL] = strap_s.duplex; // RL6
          adv_load[psc_pkg::ADV_100_HALF] = 1'b1;
          adv_load[psc_pkg::ADV_10_FULL] = 1'b0;
          adv_load[psc_pkg::ADV_10_HALF] = 1'b0;
        end
        2'b01: begin
          adv_load[psc_pkg::ADV_100_FULL] = 1'b0; // RL7
          adv_load[psc_pkg::ADV_100_HALF] = 1'b0;
          adv_load[psc_pkg::ADV_10_FULL] = strap_s.duplex;
          adv_load[psc_pkg::ADV_10_HALF] = 1'b1;
        end
        2'b00: begin
          adv_load = psc_pkg::ADV_RST; // RL18
        end
      endcase
    end
  end

  // APB decode; the response is prepared one cycle into the access phase.
  assign acc_idx = paddr[psc_pkg::IDX_MSB:psc_pkg::IDX_LSB];
  assign acc_hit = reset_done_r &&
    (paddr[psc_pkg::PHY_MSB:psc_pkg::PHY_LSB] ==
     mode_r[psc_pkg::MODE_PAD_MSB:psc_pkg::MODE_PAD_LSB]); // RL12
  assign acc_known = (acc_idx == psc_pkg::IDX_CONTROL) ||
    (acc_idx == psc_pkg::IDX_ADVERT) || (acc_idx == psc_pkg::IDX_TX100_CTL) ||
    (acc_idx == psc_pkg::IDX_MODE_CTL);
  assign commit = psel && penable && pready_r && pwrite && acc_hit;

  always_comb begin
    unique case (acc_idx)
      psc_pkg::IDX_CONTROL: rd_word = ctl_r;
      psc_pkg::IDX_ADVERT: rd_word = adv_r;
      psc_pkg::IDX_TX100_CTL: rd_word = tx_r;
      psc_pkg::IDX_MODE_CTL: rd_word = mode_r;
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (psel && penable && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= !(acc_hit && acc_known); // RL12
      prdata_r <= (acc_hit && !pwrite) ? {16'h0000, rd_word} : 32'h00000000;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // Strap values land once in the load cycle; later only writes apply.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= psc_pkg::CTL_RST;
    end else if (st_r == psc_pkg::ST_LOAD) begin
      ctl_r <= ctl_load; // RL17
    end else if (commit && acc_idx == psc_pkg::IDX_CONTROL) begin
      ctl_r <= (ctl_r & ~psc_pkg::CTL_WMASK) |
               (pwdata[15:0] & psc_pkg::CTL_WMASK); // RL4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_r <= psc_pkg::ADV_RST;
    end else if (st_r == psc_pkg::ST_LOAD) begin
      adv_r <= adv_load;
    end else if (commit && acc_idx == psc_pkg::IDX_ADVERT) begin
      adv_r <= (adv_r & ~psc_pkg::ADV_WMASK) |
               (pwdata[15:0] & psc_pkg::ADV_WMASK); // RL4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_r <= psc_pkg::TX_RST;
    end else if (st_r == psc_pkg::ST_LOAD) begin
      tx_r <= tx_load;
    end else if (commit && acc_idx == psc_pkg::IDX_TX100_CTL) begin
      tx_r <= (tx_r & ~psc_pkg::TX_WMASK) |
              (pwdata[15:0] & psc_pkg::TX_WMASK); // RL4
    end
  end

  // The sampled pad levels fix both the PHY address and the LED polarity.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= psc_pkg::MODE_RST;
      led_pol_r <= 5'h00;
    end else if (st_r == psc_pkg::ST_LOAD) begin
      mode_r[psc_pkg::MODE_PAD_MSB:psc_pkg::MODE_PAD_LSB] <= pad_s; // RL15 RL10
      led_pol_r <= pad_s; // RL9
    end
  end

  // LED drivers stay off the shared pins until the levels have been taken.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_o <= 5'h00;
      led_oe <= 5'h00;
    end else begin
      led_o <= led_state ^ led_pol_r; // RL9
      led_oe <= {psc_pkg::PAD_W{reset_done_r}};
    end
  end

  assign reset_done = reset_done_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  assign cfg_o = '{
    loopback: ctl_r[psc_pkg::CTL_LOOPBACK],
    speed_100: ctl_r[psc_pkg::CTL_SPEED],
    autoneg: ctl_r[psc_pkg::CTL_AUTONEG],
    power_down: ctl_r[psc_pkg::CTL_PWRDN],
    isolate: ctl_r[psc_pkg::CTL_ISOLATE],
    restart_an: ctl_r[psc_pkg::CTL_RESTART],
    duplex: ctl_r[psc_pkg::CTL_DUPLEX],
    coll_test: ctl_r[psc_pkg::CTL_COLTEST],
    nrzi: tx_r[psc_pkg::TX_NRZI],
    block_code: tx_r[psc_pkg::TX_BLOCK_CODE],
    mlt3_bypass: tx_r[psc_pkg::TX_MLT3_BYPASS],
    scramble_off: tx_r[psc_pkg::TX_SCRAMBLE_OFF],
    phy_addr: mode_r[psc_pkg::MODE_PAD_MSB:psc_pkg::MODE_PAD_LSB]
  };

  a_autoneg_scramble: assert property ( // RL1
    @(posedge pclk) disable iff (!presetn)
    st_r == psc_pkg::ST_LOAD |=>
      ctl_r[psc_pkg::CTL_AUTONEG] == $past(strap_s.autoneg) &&
      tx_r[psc_pkg::TX_SCRAMBLE_OFF] == $past(strap_s.scramble_off))
    else $error("autoneg or scrambler strap not loaded");

  a_nrzi_block_load: assert property ( // RL2
    @(posedge pclk) disable iff (!presetn)
    st_r == psc_pkg::ST_LOAD |=>
      tx_r[psc_pkg::TX_NRZI] == $past(strap_s.nrzi) &&
      tx_r[psc_pkg::TX_BLOCK_CODE] == $past(strap_s.block_code))
    else $error("nrzi or block code strap not loaded");

  a_speed_load: assert property ( // RL3
    @(posedge pclk) disable iff (!presetn)
    st_r == psc_pkg::ST_LOAD |=>
      ctl_r[psc_pkg::CTL_SPEED] == $past(strap_s.speed))
    else $error("speed strap not loaded");

  a_regs_hold_run: assert property ( // RL4
    @(posedge pclk) disable iff (!presetn)
    st_r == psc_pkg::ST_RUN && !commit |=> $stable(ctl_r) &&
      $stable(adv_r) && $stable(tx_r) && $stable(mode_r))
    else $error("register changed without a management write");

  a_adv_all: assert property ( // RL5
    @(posedge pclk) disable iff (!presetn)
    st_r == psc_pkg::ST_LOAD && strap_s.autoneg && strap_s.adv_select_a &&
      strap_s.adv_select_b |=>
      adv_r[8:5] == {$past(strap_s.duplex), 1'b1, $past(strap_s.duplex), 1'b1})
    else $error("advertise pattern for both selects wrong");

  a_adv_100_only: assert property ( // RL6
    @(posedge pclk) disable iff (!presetn)
    st_r == psc_pkg::ST_LOAD && strap_s.autoneg && strap_s.adv_select_a &&
      !strap_s.adv_select_b |=>
      adv_r[8:5] == {$past(strap_s.duplex), 3'b100})
    else $error("advertise pattern for 100 only wrong");

  a_adv_10_only: assert property ( // RL7
    @(posedge pclk) disable iff (!presetn)
    st_r == psc_pkg::ST_LOAD && strap_s.autoneg && !strap_s.adv_select_a &&
      strap_s.adv_select_b |=>
      adv_r[8:5] == {2'b00, $past(strap_s.duplex), 1'b1})
    else $error("advertise pattern for 10 only wrong");

  a_adv_default: assert property ( // RL8
    @(posedge pclk) disable iff (!presetn)
    st_r == psc_pkg::ST_LOAD && (!strap_s.autoneg ||
      (!strap_s.adv_select_a && !strap_s.adv_select_b)) |=>
      adv_r == psc_pkg::ADV_RST)
    else $error("advertise defaults not kept");

  a_isolate_zero: assert property ( // RL11
    @(posedge pclk) disable iff (!presetn)
    st_r == psc_pkg::ST_LOAD |=>
      ctl_r[psc_pkg::CTL_ISOLATE] == ($past(pad_s) == psc_pkg::PAD_ISOLATE))
    else $error("isolate bit does not follow zero address");

  a_foreign_addr: assert property ( // RL12
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_r && !acc_hit |=> pslverr_r &&
      prdata_r == 32'h00000000)
    else $error("access to another PHY address was answered");

  a_an_off_pins: assert property ( // RL13
    @(posedge pclk) disable iff (!presetn)
    st_r == psc_pkg::ST_LOAD && !strap_s.autoneg |=>
      tx_r[psc_pkg::TX_MLT3_BYPASS] == $past(strap_s.adv_select_a) &&
      ctl_r[psc_pkg::CTL_LOOPBACK] == $past(strap_s.adv_select_b)) // RL14
    else $error("autoneg-off select pins not applied");

  a_done_after_load: assert property ( // RL16
    @(posedge pclk) disable iff (!presetn)
    st_r != psc_pkg::ST_RUN |-> !reset_done_r ##1
      (st_r != psc_pkg::ST_RUN || reset_done_r))
    else $error("reset done not tied to the load");

  a_led_polarity: assert property ( // RL9
    @(posedge pclk) disable iff (!presetn)
    reset_done_r |=> led_o == ($past(led_state) ^
      mode_r[psc_pkg::MODE_PAD_MSB:psc_pkg::MODE_PAD_LSB]) && led_oe == 5'h1f)
    else $error("LED polarity does not follow the sampled pad");

endmodule // psc_loader

// >>> rtl/psc_pkg.sv
// Package for the strap configuration loader: offsets, fields, resets, types.
package psc_pkg;

  // Clock and reset-completion timing.
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned RST_TIME_NS = 1000000;
  localparam int unsigned RST_CYCLES = (RST_TIME_NS * 1000) / CLK_PERIOD_PS;

  // Register indices; the byte address is four times the index.
  localparam logic [4:0] IDX_CONTROL = 5'h00;
  localparam logic [4:0] IDX_ADVERT = 5'h04;
  localparam logic [4:0] IDX_TX100_CTL = 5'h13;
  localparam logic [4:0] IDX_MODE_CTL = 5'h14;

  // APB address layout: PHY address select above the register word index.
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 6;
  localparam int unsigned PHY_LSB = 7;
  localparam int unsigned PHY_MSB = 11;

  // Control register fields.
  localparam int unsigned CTL_LOOPBACK = 14;
  localparam int unsigned CTL_SPEED = 13;
  localparam int unsigned CTL_AUTONEG = 12;
  localparam int unsigned CTL_PWRDN = 11;
  localparam int unsigned CTL_ISOLATE = 10;
  localparam int unsigned CTL_RESTART = 9;
  localparam int unsigned CTL_DUPLEX = 8;
  localparam int unsigned CTL_COLTEST = 7;
  localparam logic [15:0] CTL_RST = 16'h3000;
  localparam logic [15:0] CTL_WMASK = 16'h7f80;

  // Advertisement register fields.
  localparam int unsigned ADV_100_FULL = 8;
  localparam int unsigned ADV_100_HALF = 7;
  localparam int unsigned ADV_10_FULL = 6;
  localparam int unsigned ADV_10_HALF = 5;
  localparam logic [15:0] ADV_RST = 16'h01e1;
  localparam logic [15:0] ADV_WMASK = 16'h01e0;

  // 100 Mbps transmit control fields.
  localparam int unsigned TX_NRZI = 7;
  localparam int unsigned TX_BLOCK_CODE = 6;
  localparam int unsigned TX_MLT3_BYPASS = 1;
  localparam int unsigned TX_SCRAMBLE_OFF = 0;
  localparam logic [15:0] TX_RST = 16'h00c0;
  localparam logic [15:0] TX_WMASK = 16'h00c3;

  // Mode control: sampled LED/address levels live in bits 7 down to 3.
  localparam int unsigned MODE_PAD_LSB = 3;
  localparam int unsigned MODE_PAD_MSB = 7;
  localparam logic [15:0] MODE_RST = 16'h0000;

  localparam int unsigned PAD_W = 5;
  localparam logic [4:0] PAD_ISOLATE = 5'h00;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } psc_state_t;

  typedef struct packed {
    logic autoneg;
    logic nrzi;
    logic block_code;
    logic scramble_off;
    logic speed;
    logic adv_select_a;
    logic adv_select_b;
    logic duplex;
  } psc_strap_t;

  localparam int unsigned STRAP_W = $bits(psc_strap_t);

  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic autoneg;
    logic power_down;
    logic isolate;
    logic restart_an;
    logic duplex;
    logic coll_test;
    logic nrzi;
    logic block_code;
    logic mlt3_bypass;
    logic scramble_off;
    logic [4:0] phy_addr;
  } psc_cfg_t;

endpackage

// >>> rtl/psc_sync.sv
// Two-flop synchroniser bank for pin levels entering the pclk domain.
module psc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule // psc_sync

// >>> testbench/psc_board_model.sv
// Board model: strap resistors and the shared LED/address pad wires.
module psc_board_model (
  input wire psc_pkg::psc_strap_t strap_set,
  input wire logic [4:0] pull_set,
  input wire logic [4:0] led_o,
  input wire logic [4:0] led_oe,
  output psc_pkg::psc_strap_t strap_in,
  output logic [4:0] pad_in
);
  assign strap_in = strap_set;
  // A pad shows its resistor level unless the device drives it.
  assign pad_in = (led_oe & led_o) | (~led_oe & pull_set);
endmodule // psc_board_model

// >>> testbench/tb_phy_strap_config_loader.sv
// Testbench for the strap loader: strap patterns, APB reads and writes.
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_phy_strap_config_loader;
  timeunit 1ns;
  timeprecision 100ps;
  // Short wait count keeps each reset cheap; it still covers synchroniser settle.
  localparam int unsigned RSTC = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, reset_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  psc_pkg::psc_strap_t strap_set, strap_in, s;
  logic [4:0] pull_set, pad_in, led_state, led_o, led_oe, p;
  psc_pkg::psc_cfg_t cfg_o;
  int miscompares, n_checks, cyc;
  logic [15:0] rd, ea, ec, et;
  logic err;
  logic [12:0] tbl [9] = '{{8'hef, 5'h01}, {8'hb6, 5'h1f}, {8'hcd, 5'h00},
    {8'h84, 5'h0a}, {8'hfb, 5'h15}, {8'haa, 5'h10}, {8'hd1, 5'h03},
    {8'h6f, 5'h1e}, {8'h10, 5'h07}};

  psc_loader #(.RST_CYCLES(RSTC)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_in(strap_in), .pad_in(pad_in), .led_state(led_state),
    .led_o(led_o), .led_oe(led_oe), .reset_done(reset_done), .cfg_o(cfg_o));

  psc_board_model u_board (.strap_set(strap_set), .pull_set(pull_set),
    .led_o(led_o), .led_oe(led_oe), .strap_in(strap_in), .pad_in(pad_in));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [15:0] e_adv(psc_pkg::psc_strap_t t);
    logic [3:0] f;
    case ({t.adv_select_a, t.adv_select_b})
      2'b11: f = {t.duplex, 1'b1, t.duplex, 1'b1};
      2'b10: f = {t.duplex, 1'b1, 2'b00};
      2'b01: f = {2'b00, t.duplex, 1'b1};
      default: f = 4'hf;
    endcase
    if (!t.autoneg) f = 4'hf;
    return {7'h00, f, 5'h01};
  endfunction

  function automatic logic [15:0] e_ctl(psc_pkg::psc_strap_t t,
                                       logic [4:0] q);
    return {1'b0, ~t.autoneg & t.adv_select_b, t.speed, t.autoneg, 1'b0,
      q == 5'h00, 1'b0, ~t.autoneg & t.duplex, 8'h00};
  endfunction

  function automatic logic [15:0] e_tx(psc_pkg::psc_strap_t t);
    return {8'h00, t.nrzi, t.block_code, 4'h0,
      ~t.autoneg & t.adv_select_a, t.scramble_off};
  endfunction

  // The request stands until pready is seen high at a rising edge; data and
  // error flag are taken at that edge, and only the bench timeout ends a hang.
  task automatic apb(input logic wr, input logic [4:0] phy,
                     input logic [4:0] idx, input logic [15:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {phy, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input psc_pkg::psc_strap_t t, input logic [4:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    presetn <= 1'b0;
    strap_set <= t;
    pull_set <= q;
    led_state <= 5'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, q, psc_pkg::IDX_CONTROL, 16'h0000);
    `CHK(err, 1'b1)
    @(negedge pclk);
    `CHK(reset_done, 1'b0)
    while (reset_done !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    `CHK(reset_done, 1'b1)
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    strap_set = 8'h00;
    pull_set = 5'h00;
    led_state = 5'h00;
    miscompares = 0;
    n_checks = 0;
    cyc = 0;
    for (int i = 0; i < 9; i++) begin
      s = tbl[i][12:5];
      p = tbl[i][4:0];
      ea = e_adv(s);
      ec = e_ctl(s, p);
      et = e_tx(s);
      do_reset(s, p);
      apb(1'b0, p, psc_pkg::IDX_CONTROL, 16'h0000);
      `CHK(err, 1'b0)
      `CHK(rd, ec)
      apb(1'b0, p, psc_pkg::IDX_ADVERT, 16'h0000);
      `CHK(rd, ea)
      apb(1'b0, p, psc_pkg::IDX_TX100_CTL, 16'h0000);
      `CHK(rd, et)
      apb(1'b0, p, psc_pkg::IDX_MODE_CTL, 16'h0000);
      `CHK(rd, {8'h00, p, 3'h0})
      `CHK(cfg_o, {ec[14:7], et[7:6], et[1:0], p})
      led_state <= 5'h16;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      `CHK(led_o, 5'h16 ^ p)
      `CHK(led_oe, 5'h1f)
      apb(1'b0, p ^ 5'h01, psc_pkg::IDX_CONTROL, 16'h0000);
      `CHK({err, rd}, 17'h10000)
      apb(1'b1, p ^ 5'h04, psc_pkg::IDX_CONTROL, ~ec);
      `CHK(err, 1'b1)
      apb(1'b0, p, 5'h01, 16'h0000);
      `CHK(err, 1'b1)
      strap_set <= ~s;
      repeat (5) @(posedge pclk);
      apb(1'b0, p, psc_pkg::IDX_CONTROL, 16'h0000);
      `CHK(rd, ec)
      apb(1'b0, p, psc_pkg::IDX_TX100_CTL, 16'h0000);
      `CHK(rd, et)
      apb(1'b1, p, psc_pkg::IDX_ADVERT, ea ^ psc_pkg::ADV_WMASK);
      apb(1'b0, p, psc_pkg::IDX_ADVERT, 16'h0000);
      `CHK(rd, ea ^ psc_pkg::ADV_WMASK)
    end
    tally_and_finish();
  end
endmodule // tb_phy_strap_config_loader
